// [verilog/dcri_top.v]
// APB register interface of the eight-channel DMA controller with per-channel engines.
// Assumes an APB master on pclk and peripheral requests as one-cycle pulses on pclk.
`timescale 1ns/1ps
`include "dcri_map.vh"
module dcri_top #(
    parameter NCH = 8,
    parameter CW = 10
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Peripheral transfer requests
    input wire [NCH-1:0] periph_req,
    // Events
    output reg [NCH-1:0] xfer_ack,
    output reg [NCH-1:0] chan_done,
    output wire irq
);
    reg [NCH*16-1:0] ctl_q;
    reg [NCH*16-1:0] req_q;
    reg [NCH*16-1:0] sta_q;
    reg [NCH*16-1:0] stb_q;
    reg [NCH*16-1:0] pad_q;
    reg [NCH*CW-1:0] cnt_q;
    reg [NCH-1:0] xwcol;
    reg [NCH-1:0] pwcol;
    wire [NCH*16-1:0] ptr_w;
    wire [NCH-1:0] sel_w;
    wire [NCH-1:0] busy_w;
    wire [NCH-1:0] xfer_w;
    wire [NCH-1:0] done_w;
    wire [NCH-1:0] xw_set;
    wire [NCH-1:0] pw_set;
    wire [NCH-1:0] iflag;
    wire [NCH-1:0] ien;
    wire [3*NCH-1:0] ipri;
    wire wr_go;
    wire rd_cap;
    wire [2:0] ch;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire coll_wr;
    wire [NCH-1:0] xw_clr;
    wire [NCH-1:0] pw_clr;
    wire [31:0] coll_word;
    wire [31:0] stat_word;
    wire map_err;

    // True when the address falls in the per-channel register window.
    function chan_win;
        input [11:0] a;
        begin
            chan_win = (a[11:8] == 4'h0);
        end
    endfunction

    // Zero-extends a 16-bit register to the bus word, so upper bits read as zero.
    function [31:0] half_word;
        input [15:0] v;
        begin
            half_word = {16'h0000, v};
        end
    endfunction

    // Chooses one channel register: channel window, channel number, field offset.
    function chan_hit;
        input [11:0] a;
        input [2:0] c;
        input [4:0] ofs;
        begin
            chan_hit = chan_win(a) && (a[7:5] == c) && (a[4:0] == ofs);
        end
    endfunction

    // Chooses one shared register by its full offset.
    function shr_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            shr_hit = (a == ofs);
        end
    endfunction

    // Writes land only at the completing edge of the access phase.
    assign wr_go = psel & penable & pready & pwrite;
    assign rd_cap = psel & penable & ~pready;
    assign ch = paddr[7:5];

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : gch
            localparam [2:0] CH = g;
            wire wr_ctl = wr_go & chan_hit(paddr, CH, `DCRI_OFS_CTL);
            wire wr_req = wr_go & chan_hit(paddr, CH, `DCRI_OFS_REQ);
            wire wr_sta = wr_go & chan_hit(paddr, CH, `DCRI_OFS_STA);
            wire wr_stb = wr_go & chan_hit(paddr, CH, `DCRI_OFS_STB);
            wire wr_pad = wr_go & chan_hit(paddr, CH, `DCRI_OFS_PAD);
            wire wr_cnt = wr_go & chan_hit(paddr, CH, `DCRI_OFS_CNT);

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ctl_q[16*g +: 16] <= `DCRI_RST_16;
                    req_q[16*g +: 16] <= `DCRI_RST_16;
                    sta_q[16*g +: 16] <= `DCRI_RST_16;
                    stb_q[16*g +: 16] <= `DCRI_RST_16;
                    pad_q[16*g +: 16] <= `DCRI_RST_16;
                    cnt_q[CW*g +: CW] <= `DCRI_RST_CNT;
                end
                else
                begin
                    if (wr_ctl)
                    begin
                        ctl_q[16*g +: 16] <= pwdata[15:0];
                    end
                    if (wr_req)
                    begin
                        req_q[16*g +: 16] <= pwdata[15:0];
                    end
                    if (wr_sta)
                    begin
                        sta_q[16*g +: 16] <= pwdata[15:0];
                    end
                    if (wr_stb)
                    begin
                        stb_q[16*g +: 16] <= pwdata[15:0];
                    end
                    if (wr_pad)
                    begin
                        pad_q[16*g +: 16] <= pwdata[15:0];
                    end
                    if (wr_cnt)
                    begin
                        cnt_q[CW*g +: CW] <= pwdata[CW-1:0];
                    end
                end
            end

            // A transfer in the same cycle as a software write to a start or pad register collides.
            assign xw_set[g] = xfer_w[g] & (wr_sta | wr_stb);
            assign pw_set[g] = xfer_w[g] & wr_pad;

            dcri_chan #(
                .CW(CW)
            ) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .enable(ctl_q[16*g + `DCRI_CTL_EN]),
                .pingpong(ctl_q[16*g + `DCRI_CTL_PP]),
                .start_a(sta_q[16*g +: 16]),
                .start_b(stb_q[16*g +: 16]),
                .tcount(cnt_q[CW*g +: CW]),
                .req(periph_req[g]),
                .ptr(ptr_w[16*g +: 16]),
                .buf_sel(sel_w[g]),
                .busy(busy_w[g]),
                .xfer(xfer_w[g]),
                .done(done_w[g])
            );
        end
    endgenerate

    // Collision flags: write one to clear, a new collision wins.
    // The clear masks are zero outside a completing write to the collision word.
    assign coll_wr = wr_go & shr_hit(paddr, `DCRI_OFS_COLL);
    assign xw_clr = coll_wr ? pwdata[NCH-1:0] : {NCH{1'b0}};
    assign pw_clr = coll_wr ? pwdata[NCH+7:8] : {NCH{1'b0}};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xwcol <= {NCH{1'b0}};
        end
        else
        begin
            xwcol <= (xwcol & ~xw_clr) | xw_set;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwcol <= {NCH{1'b0}};
        end
        else
        begin
            pwcol <= (pwcol & ~pw_clr) | pw_set;
        end
    end

    // Shared status words are assembled once, so every read sees one layout.
    assign coll_word = half_word({pwcol, xwcol});
    assign stat_word = half_word({busy_w, sel_w});

    dcri_irq #(
        .N(NCH)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(done_w),
        .flag_wr(wr_go & shr_hit(paddr, `DCRI_OFS_IFLAG)),
        .en_wr(wr_go & shr_hit(paddr, `DCRI_OFS_IEN)),
        .pri_wr(wr_go & shr_hit(paddr, `DCRI_OFS_IPRI)),
        .wdata(pwdata),
        .flag(iflag),
        .enable(ien),
        .prio(ipri),
        .irq(irq)
    );

    // Read data is caught in the first access cycle and shown with pready.
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
        if (chan_win(paddr))
        begin
            case (paddr[4:0])
                `DCRI_OFS_CTL:
                begin
                    rd_hit = 1'b1;
                    rd_mux = half_word(ctl_q[16*ch +: 16]);
                end
                `DCRI_OFS_REQ:
                begin
                    rd_hit = 1'b1;
                    rd_mux = half_word(req_q[16*ch +: 16]);
                end
                `DCRI_OFS_STA,
                `DCRI_OFS_STB:
                begin
                    // Both start registers read the one live pointer.
                    rd_hit = 1'b1;
                    rd_mux = half_word(ptr_w[16*ch +: 16]);
                end
                `DCRI_OFS_PAD:
                begin
                    rd_hit = 1'b1;
                    rd_mux = half_word(pad_q[16*ch +: 16]);
                end
                `DCRI_OFS_CNT:
                begin
                    rd_hit = 1'b1;
                    rd_mux = {{(32-CW){1'b0}}, cnt_q[CW*ch +: CW]};
                end
                default:
                begin
                    rd_hit = 1'b0;
                end
            endcase
        end
        else
        begin
            case (paddr)
                `DCRI_OFS_COLL:
                begin
                    rd_hit = 1'b1;
                    rd_mux = coll_word;
                end
                `DCRI_OFS_PPST:
                begin
                    rd_hit = 1'b1;
                    rd_mux = stat_word;
                end
                `DCRI_OFS_IFLAG:
                begin
                    rd_hit = 1'b1;
                    rd_mux = {24'h000000, iflag};
                end
                `DCRI_OFS_IEN:
                begin
                    rd_hit = 1'b1;
                    rd_mux = {24'h000000, ien};
                end
                `DCRI_OFS_IPRI:
                begin
                    rd_hit = 1'b1;
                    rd_mux = {8'h00, ipri};
                end
                default:
                begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    // Misaligned or unmapped addresses answer with an error and change nothing.
    assign map_err = ~rd_hit | (paddr[1:0] != 2'h0);

    // One wait state on every access keeps read data coming from flops.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_cap;
            if (rd_cap)
            begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= map_err;
            end
            else
            begin
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

    // Event outputs follow the engines by one cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xfer_ack <= {NCH{1'b0}};
            chan_done <= {NCH{1'b0}};
        end
        else
        begin
            xfer_ack <= xfer_w;
            chan_done <= done_w;
        end
    end
endmodule

// [shared/dcri_map.vh]
// Register map, field positions, reset values and steps of the DMA channel register block.
// Assumes inclusion by every design file of the block; holds definitions only.
`ifndef DCRI_MAP_VH
`define DCRI_MAP_VH
`define DCRI_OFS_CTL 5'h00
`define DCRI_OFS_REQ 5'h04
`define DCRI_OFS_STA 5'h08
`define DCRI_OFS_STB 5'h0C
`define DCRI_OFS_PAD 5'h10
`define DCRI_OFS_CNT 5'h14
`define DCRI_OFS_COLL 12'h100
`define DCRI_OFS_PPST 12'h104
`define DCRI_OFS_IFLAG 12'h108
`define DCRI_OFS_IEN 12'h10C
`define DCRI_OFS_IPRI 12'h110
`define DCRI_CTL_EN 15
`define DCRI_CTL_PP 0
`define DCRI_RST_16 16'h0000
`define DCRI_RST_CNT 10'h000
`define DCRI_RST_PRIO 3'h4
`define DCRI_PTR_STEP 16'h0002
`endif

// [verilog/dcri_chan.v]
// One channel's transfer engine: live RAM pointer, transfer index and ping-pong selection.
// Assumes requests are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`include "dcri_map.vh"
module dcri_chan #(
    parameter CW = 10
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Settings from the register file
    input wire enable,
    input wire pingpong,
    input wire [15:0] start_a,
    input wire [15:0] start_b,
    input wire [CW-1:0] tcount,
    // Request from the peripheral
    input wire req,
    // State and events
    output reg [15:0] ptr,
    output reg buf_sel,
    output wire busy,
    output reg xfer,
    output reg done
);
    reg [CW-1:0] idx;

    assign busy = enable & (idx != {CW{1'b0}});

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr <= `DCRI_RST_16;
            buf_sel <= 1'b0;
            idx <= {CW{1'b0}};
            xfer <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            xfer <= 1'b0;
            done <= 1'b0;
            if (!enable)
            begin
                // An idle channel shows its start value, so a fresh enable begins there.
                idx <= {CW{1'b0}};
                buf_sel <= 1'b0;
                ptr <= start_a;
            end
            else if (req)
            begin
                xfer <= 1'b1;
                if (idx == tcount)
                begin
                    done <= 1'b1;
                    idx <= {CW{1'b0}};
                    if (pingpong)
                    begin
                        buf_sel <= ~buf_sel;
                        ptr <= buf_sel ? start_a : start_b;
                    end
                    else
                    begin
                        ptr <= buf_sel ? start_b : start_a;
                    end
                end
                else
                begin
                    idx <= idx + {{(CW-1){1'b0}}, 1'b1};
                    ptr <= ptr + `DCRI_PTR_STEP;
                end
            end
        end
    end
endmodule

// [verilog/dcri_irq.v]
// Completion flags, enables and priorities with one level interrupt output.
// Assumes write strobes are one-cycle pulses at the bus completion edge.
`timescale 1ns/1ps
`include "dcri_map.vh"
module dcri_irq #(
    parameter N = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Events and software writes
    input wire [N-1:0] set_in,
    input wire flag_wr,
    input wire en_wr,
    input wire pri_wr,
    input wire [31:0] wdata,
    // State
    output reg [N-1:0] flag,
    output reg [N-1:0] enable,
    output reg [3*N-1:0] prio,
    output reg irq
);
    wire [N-1:0] live;
    wire [N-1:0] clr;

    assign clr = flag_wr ? wdata[N-1:0] : {N{1'b0}};

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : gl
            // Priority zero turns the source off.
            assign live[g] = flag[g] & enable[g] & (prio[3*g +: 3] != 3'h0);
        end
    endgenerate

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag <= {N{1'b0}};
            enable <= {N{1'b0}};
            // Every source starts at a middle priority; enables still gate the output.
            prio <= {N{`DCRI_RST_PRIO}};
            irq <= 1'b0;
        end
        else
        begin
            // A completion in the clearing cycle stays set.
            flag <= (flag & ~clr) | set_in;
            if (en_wr)
            begin
                enable <= wdata[N-1:0];
            end
            if (pri_wr)
            begin
                prio <= wdata[3*N-1:0];
            end
            irq <= |live;
        end
    end
endmodule

// [bench/dcri_periph.sv]
// Peripheral request model: turns a trigger mask into request pulses.
// Assumes the bench raises trig for single cycles on pclk.
`timescale 1ns/1ps
module dcri_periph (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Trigger and requests
    input wire [7:0] trig,
    output reg [7:0] req
);
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            req <= 8'h00;
        else
            req <= trig;
endmodule

// [bench/dcri_properties.sv]
// Port checker of the DMA channel register block.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`timescale 1ns/1ps
module dcri_properties #(
    parameter NCH = 8,
    parameter CW = 10
) (
    // Clock, reset and APB
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Channels
    input wire [NCH-1:0] periph_req,
    input wire [NCH-1:0] xfer_ack,
    input wire [NCH-1:0] chan_done,
    input wire irq
);
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    wire bad = paddr[1:0] != 2'h0 || paddr > 12'h110 ||
        (paddr < 12'h100 && paddr[4:0] > 5'h14);
    wire cnt_rd = rd_done && !bad && paddr < 12'h100 && paddr[4:0] == 5'h14;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood too long");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    one_wait_a: assert property ($rose(psel && penable) |=> pready)
        else $error("wrong wait count");
    err_map_a: assert property (pready |-> pslverr == bad)
        else $error("error response off map");
    read_idle_a: assert property (!rd_done |-> prdata == 32'h0)
        else $error("stray read data");
    reg_width_a: assert property ((rd_done && paddr != 12'h110) |-> prdata[31:16] == 16'h0)
        else $error("register too wide");
    count_width_a: assert property (cnt_rd |-> prdata[15:CW] == '0)
        else $error("count too wide");
    ack_cause_a: assert property ((xfer_ack & ~$past(periph_req, 2)) == '0)
        else $error("ack without request");
    done_ack_a: assert property ((chan_done & ~xfer_ack) == '0)
        else $error("done without transfer");
    irq_rise_a: assert property ($rose(irq) |->
        $past(|chan_done) || $past(wr_done) || $past(wr_done, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("irq fell without write");
endmodule

// [bench/dcri_bench.sv]
// Self-checking bench of the DMA channel register block over APB.
// Assumes dcri_top, dcri_periph and dcri_properties are compiled first.
`timescale 1ns/1ps
module dcri_bench;
    reg pclk;
    reg presetn;
    reg [11:0] paddr;
    reg psel;
    reg penable;
    reg pwrite;
    reg [31:0] pwdata;
    reg [7:0] trig;
    reg [31:0] rd;
    reg err;
    reg [11:0] b;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [7:0] periph_req;
    wire [7:0] xfer_ack;
    wire [7:0] chan_done;
    wire irq;
    integer error_cnt;
    integer check_count;
    integer acks;
    integer dones;
    integer i;

    dcri_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
        .xfer_ack(xfer_ack), .chan_done(chan_done), .irq(irq));
    dcri_periph peri (.pclk(pclk), .presetn(presetn), .trig(trig), .req(periph_req));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        acks <= acks + xfer_ack[2];
        dones <= dones + chan_done[2];
    end

    task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    // A nonzero hit lands the request in the wait state, so its transfer meets the write.
    task apb(input w, input [11:0] a, input [31:0] d, input [7:0] hit);
        integer n;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        trig <= hit;
        @(posedge pclk);
        penable <= 1'b1;
        trig <= 8'h00;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 9)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d, 8'h00);
    endtask

    task rdc(input string what, input [11:0] a, input [31:0] exp);
    begin
        apb(1'b0, a, 32'h0, 8'h00);
        chk(what, rd, exp);
    end
    endtask

    task pulse;
    begin
        trig <= 8'h04;
        @(posedge pclk);
        trig <= 8'h00;
        repeat (4) @(posedge pclk);
    end
    endtask

    task irq_is(input exp);
    begin
        @(posedge pclk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    end
    endtask

    task t_regs;
    begin
        rdc("reset", 12'h0E0, 32'h0);
        rdc("prio reset", 12'h110, 32'h00924924);
        for (i = 0; i < 8; i = i + 1)
        begin
            b = {4'h0, i[2:0], 5'h00};
            wr(b, 32'hFFFF_7A50 + i);
            wr(b + 12'h004, 32'hFFFF_5A00 + i);
            wr(b + 12'h010, 32'hFFFF_C3C0 + i);
            wr(b + 12'h014, 32'hFFFF_FFFF);
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            b = {4'h0, i[2:0], 5'h00};
            rdc("control", b, 32'h7A50 + i);
            rdc("select", b + 12'h004, 32'h5A00 + i);
            rdc("periph", b + 12'h010, 32'hC3C0 + i);
            rdc("count", b + 12'h014, 32'h3FF);
        end
        rdc("hole", 12'h018, 32'h0);
        chk("hole err", {31'h0, err}, 32'h1);
        wr(12'h008, 32'h1000);
        wr(12'h00C, 32'h2000);
        rdc("start a", 12'h008, 32'h1000);
        rdc("start b", 12'h00C, 32'h1000);
        $display("register test over");
    end
    endtask

    task t_xfer;
    begin
        wr(12'h048, 32'h1000);
        wr(12'h054, 32'h2);
        wr(12'h110, 32'h40);
        rdc("prio", 12'h110, 32'h40);
        wr(12'h10C, 32'h4);
        wr(12'h040, 32'h8000);
        pulse;
        chk("acks", acks, 32'h1);
        rdc("live", 12'h048, 32'h1002);
        rdc("busy", 12'h104, 32'h400);
        pulse;
        pulse;
        chk("acks", acks, 32'h3);
        chk("dones", dones, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        rdc("reload", 12'h048, 32'h1000);
        rdc("flags", 12'h108, 32'h4);
        wr(12'h10C, 32'h0);
        irq_is(1'b0);
        wr(12'h10C, 32'h4);
        irq_is(1'b1);
        wr(12'h110, 32'h0);
        irq_is(1'b0);
        wr(12'h110, 32'h40);
        irq_is(1'b1);
        wr(12'h108, 32'h4);
        irq_is(1'b0);
        $display("transfer test over");
    end
    endtask

    task t_pp;
    begin
        wr(12'h040, 32'h0);
        wr(12'h04C, 32'h2000);
        wr(12'h054, 32'h0);
        wr(12'h040, 32'h8001);
        wr(12'h104, 32'hFFFF);
        pulse;
        rdc("ping", 12'h048, 32'h2000);
        apb(1'b0, 12'h104, 32'h0, 8'h00);
        chk("select", rd & 32'hFF, 32'h4);
        pulse;
        rdc("pong", 12'h04C, 32'h1000);
        apb(1'b0, 12'h104, 32'h0, 8'h00);
        chk("select", rd & 32'hFF, 32'h0);
        $display("ping-pong test over");
    end
    endtask

    task t_coll;
    begin
        apb(1'b1, 12'h048, 32'h1000, 8'h04);
        rdc("ram coll", 12'h100, 32'h4);
        apb(1'b1, 12'h050, 32'h0, 8'h04);
        rdc("per coll", 12'h100, 32'h404);
        wr(12'h100, 32'h404);
        rdc("coll clr", 12'h100, 32'h0);
        $display("collision test over");
    end
    endtask

    task final_report;
    begin
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        trig = 8'h00;
        error_cnt = 0;
        check_count = 0;
        acks = 0;
        dones = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_xfer;
        t_pp;
        t_coll;
        final_report;
    end

    initial
    begin
        #500000;
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule

bind dcri_top dcri_properties #(.NCH(NCH), .CW(CW)) props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .xfer_ack(xfer_ack), .chan_done(chan_done), .irq(irq));
